// >>> hw/nmp_map.vh
// Constants of the memory-map and nonvolatile-protection block.
// Assumes one clock domain; included by nmp_top.v.
// Function
// RL1: Flash programming starts only from code running in the boot section.
// RL2: Application table equals boot size and uses its own lock bits.
// RL3: Factory signature row refuses writes and erases, reads stay allowed.
// RL4: Reset loads some factory calibration values into their modules.
// RL5: User signature page is read/write and survives chip erase.
// RL6: Fuses are written only by the programmer; software may read them.
// RL7: Lock bits may only be made stricter, by software or programmer.
// RL8: Chip erase clears lock bits only after flash erase completes.
// RL9: Unprogrammed fuse or lock bit reads one, programmed reads zero.
// RL10: Data space: I/O 0-FFF, EEPROM 1000-1FFF, SRAM 2000-5FFF.
// RL11: EEPROM has its own space by default, optionally mapped in data space.
// RL12: Mapped EEPROM window starts at data address 0x1000.
// RL13: Short I/O reaches 0x00-0x3F; bit operations only 0x00-0x1F.
// RL14: Lowest 16 I/O addresses are general purpose bit registers.
// RL15: Different masters may access different memory sets at once.
// RL16: I/O one cycle; SRAM write one, read two, burst every cycle.
// RL17: EEPROM load one cycle, read three, burst every second cycle.
// RL18: A three-byte identifier and a separate revision register exist.
// RL19: Disabled scan port blocks external access; its pins become I/O.
// RL20: Safety lock blocks clock, event, waveform register writes.
// RL21: Flash page writes; Z[8:1] word in page, Z[18:9] page.
// RL22: EEPROM ADDR[4:0] byte in 32-byte page, ADDR[11:5] page.
// RL23: Forbidden flash accesses are silently dropped; the code drops them but also sets flash_refused in the status register.
`ifndef NMP_MAP_VH
`define NMP_MAP_VH
// Register byte offsets
`define NMP_CTRL_OFS 8'h00
`define NMP_LOCK_OFS 8'h04
`define NMP_FUSE_OFS 8'h08
`define NMP_STAT_OFS 8'h0c
`define NMP_ID_OFS 8'h10
`define NMP_REV_OFS 8'h14
`define NMP_EEADDR_OFS 8'h18
// Control fields
`define NMP_CTRL_EEMAP 0
`define NMP_CTRL_SCANOFF 1
`define NMP_CTRL_SLOCK 2
// Fuse fields
`define NMP_FUSE_SCANEN 0
// Reset values
`define NMP_LOCK_RST 8'hff
`define NMP_FUSE_RST 8'hff
// Data space bounds
`define NMP_IO_END 16'h0fff
`define NMP_EE_BASE 16'h1000
`define NMP_EE_END 16'h1fff
`define NMP_SRAM_BASE 16'h2000
`define NMP_SRAM_END 16'h5fff
`define NMP_SHORT_END 16'h003f
`define NMP_BITOP_END 16'h001f
`define NMP_GPR_END 16'h000f
// Access latencies in cycles
`define NMP_LAT_IO 2'd1
`define NMP_LAT_SRAM_WR 2'd1
`define NMP_LAT_SRAM_RD 2'd2
`define NMP_LAT_SRAM_BURST 2'd1
`define NMP_LAT_EE_WR 2'd1
`define NMP_LAT_EE_RD 2'd3
`define NMP_LAT_EE_BURST 2'd2
`endif

// >>> hw/nmp_top.v
// Memory map decode, access timing and nonvolatile protection.
// Assumes CPU, DMA and programmer logic on mclk; AHB-Lite register slave.
`timescale 1ns/100ps
`default_nettype none
`include "nmp_map.vh"
module nmp_top #(
  parameter BOOT_WORD_BASE = 18'h20000,
  parameter BOOT_WORDS = 18'h01000,
  parameter [23:0] DEVICE_ID = 24'h5a_a5_3c, // Arbitrary value
  parameter [7:0] REVISION = 8'h01, // Arbitrary value
  parameter CAL_WORDS = 2,
  parameter [15:0] CLK_IO_BASE = 16'h0040,
  parameter [15:0] CLK_IO_END = 16'h007f,
  parameter [15:0] EVT_IO_BASE = 16'h0180,
  parameter [15:0] EVT_IO_END = 16'h01bf,
  parameter [15:0] AWU_IO_BASE = 16'h0880,
  parameter [15:0] AWU_IO_END = 16'h088f
) (
  input wire mclk,
  input wire rstn,
  // AHB-Lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire ccp_open,
  // Flash access check
  input wire flash_req,
  input wire flash_we,
  input wire [1:0] flash_region,
  input wire [18:0] flash_z,
  input wire [17:0] cpu_pc,
  input wire flash_from_prog,
  output wire flash_rd_grant,
  output wire flash_wr_grant,
  output wire [9:0] flash_page_index,
  output wire [7:0] flash_word_index,
  // Programmer
  input wire prog_fuse_we,
  input wire [7:0] prog_fuse_data,
  input wire prog_lock_we,
  input wire [7:0] prog_lock_data,
  input wire prog_chip_erase,
  input wire flash_erase_done,
  output reg flash_chip_erase,
  // Calibration load from signature row
  output reg [3:0] sig_raddr,
  input wire [7:0] sig_rdata,
  output reg [8*CAL_WORDS-1:0] cal_data,
  output reg cal_valid,
  // Data space masters: 0 CPU, 1 DMA
  input wire [1:0] m_req,
  input wire [1:0] m_we,
  input wire [1:0] m_burst,
  input wire [31:0] m_addr,
  output wire [1:0] m_ready,
  output wire [5:0] m_sel,
  output wire [1:0] m_io_we_ok,
  output wire io_bitop_ok,
  output wire io_short_ok,
  output wire io_gpr_sel,
  output wire [6:0] eeprom_page_index,
  output wire [4:0] eeprom_byte_index,
  // Scan port
  output wire scan_port_en,
  output wire scan_pins_gpio
);

localparam REG_MAIN = 2'd0;
localparam REG_PSIG = 2'd1;
localparam REG_USIG = 2'd2;
localparam ERS_IDLE = 2'd0;
localparam ERS_FLASH = 2'd1;
localparam ERS_LOCKS = 2'd2;
localparam SEL_IO = 2'd0;
localparam SEL_EE = 2'd1;
localparam SEL_SRAM = 2'd2;
localparam SEL_NONE = 2'd3;

// Data space decode shared by both masters
function [1:0] space_of;
  input [15:0] a;
  input ee_mapped;
  begin
    if (a <= `NMP_IO_END)
      space_of = SEL_IO; // [RL10]
    else if (a >= `NMP_EE_BASE && a <= `NMP_EE_END)
      space_of = ee_mapped ? SEL_EE : SEL_NONE; // [RL11] [RL12]
    else if (a >= `NMP_SRAM_BASE && a <= `NMP_SRAM_END)
      space_of = SEL_SRAM;
    else
      space_of = SEL_NONE;
  end
endfunction

// Writes blocked by the safety lock
function guarded;
  input [15:0] a;
  begin
    guarded = (a >= CLK_IO_BASE && a <= CLK_IO_END) ||
      (a >= EVT_IO_BASE && a <= EVT_IO_END) ||
      (a >= AWU_IO_BASE && a <= AWU_IO_END);
  end
endfunction

reg [2:0] ctrl;
reg [7:0] lock_bits;
reg [7:0] fuse;
reg [11:0] ee_addr;
reg lock_refused;
reg fuse_refused;
reg flash_refused;
reg [1:0] ers_state;

////////////////////////////////////////////////////////////////////////
// AHB-Lite slave, zero wait state
reg dp_wr;
reg dp_rd;
reg [7:0] dp_addr;
wire ap_take;
wire [7:0] stat_word;
reg [31:0] next_rdata;

assign ap_take = hsel & hready & htrans[1];
assign hreadyout = 1'b1;
assign hresp = 1'b0;
assign stat_word = {3'h0, ers_state != ERS_IDLE, cal_valid,
                    flash_refused, fuse_refused, lock_refused};
always @* begin
  next_rdata = 32'h0000_0000;
  case (haddr)
    `NMP_CTRL_OFS: next_rdata = {29'h0, ctrl};
    `NMP_LOCK_OFS: next_rdata = {24'h0, lock_bits}; // [RL9]
    `NMP_FUSE_OFS: next_rdata = {24'h0, fuse}; // [RL6] [RL9]
    `NMP_STAT_OFS: next_rdata = {24'h0, stat_word};
    `NMP_ID_OFS: next_rdata = {8'h00, DEVICE_ID}; // [RL18]
    `NMP_REV_OFS: next_rdata = {24'h0, REVISION}; // [RL18]
    `NMP_EEADDR_OFS: next_rdata = {20'h0, ee_addr};
    default: next_rdata = 32'h0000_0000;
  endcase
end

always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    dp_wr <= 1'b0;
    dp_rd <= 1'b0;
    dp_addr <= 8'h00;
    hrdata <= 32'h0000_0000;
  end else begin
    if (hready) begin
      dp_wr <= ap_take & hwrite;
      dp_rd <= ap_take & ~hwrite;
      dp_addr <= haddr;
    end
    if (ap_take & ~hwrite)
      hrdata <= next_rdata;
  end
end

////////////////////////////////////////////////////////////////////////
// Control, lock, fuse registers and chip erase
wire sw_ctrl_we;
wire sw_lock_we;
wire sw_fuse_we;
wire [7:0] lock_wval;
wire lock_we;
wire lock_relax;

assign sw_ctrl_we = dp_wr & (dp_addr == `NMP_CTRL_OFS);
assign sw_lock_we = dp_wr & (dp_addr == `NMP_LOCK_OFS);
assign sw_fuse_we = dp_wr & (dp_addr == `NMP_FUSE_OFS);
assign lock_we = sw_lock_we | prog_lock_we;
assign lock_wval = prog_lock_we ? prog_lock_data : hwdata[7:0];
// Relaxing means a programmed (zero) bit would go back to one
assign lock_relax = |(lock_wval & ~lock_bits);

always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    ctrl <= 3'h0;
    lock_bits <= `NMP_LOCK_RST;
    fuse <= `NMP_FUSE_RST;
    ee_addr <= 12'h000;
    lock_refused <= 1'b0;
    fuse_refused <= 1'b0;
    ers_state <= ERS_IDLE;
    flash_chip_erase <= 1'b0;
  end else begin
    if (sw_ctrl_we) begin
      ctrl[`NMP_CTRL_EEMAP] <= hwdata[`NMP_CTRL_EEMAP]; // [RL11]
      ctrl[`NMP_CTRL_SCANOFF] <= hwdata[`NMP_CTRL_SCANOFF]; // [RL19]
      if (ccp_open)
        ctrl[`NMP_CTRL_SLOCK] <= hwdata[`NMP_CTRL_SLOCK]; // [RL20]
    end
    if (dp_wr & (dp_addr == `NMP_EEADDR_OFS))
      ee_addr <= hwdata[11:0];
    if (prog_fuse_we)
      fuse <= prog_fuse_data; // [RL6]
    if (sw_fuse_we)
      fuse_refused <= 1'b1; // [RL6]
    else if (dp_rd & (dp_addr == `NMP_STAT_OFS))
      fuse_refused <= 1'b0;
    case (ers_state)
      ERS_IDLE: begin
        if (lock_we & ~lock_relax)
          lock_bits <= lock_wval; // [RL7]
        if (prog_chip_erase) begin
          ers_state <= ERS_FLASH;
          flash_chip_erase <= 1'b1;
        end
      end
      ERS_FLASH: begin
        if (flash_erase_done) begin // [RL8]
          ers_state <= ERS_LOCKS;
          flash_chip_erase <= 1'b0;
        end
      end
      ERS_LOCKS: begin
        lock_bits <= `NMP_LOCK_RST; // [RL8]
        ers_state <= ERS_IDLE;
      end
      default: ers_state <= ERS_IDLE;
    endcase
    if (lock_we & lock_relax)
      lock_refused <= 1'b1; // [RL7]
    else if (dp_rd & (dp_addr == `NMP_STAT_OFS))
      lock_refused <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////
// Flash section protection
wire [17:0] word_addr;
wire in_boot;
wire in_table;
wire [1:0] sec_lock;
wire pc_in_boot;
wire main_rd_ok;
wire main_wr_ok;
reg rd_ok;
reg wr_ok;

assign word_addr = flash_z[18:1];
assign flash_word_index = flash_z[8:1]; // [RL21]
assign flash_page_index = flash_z[18:9]; // [RL21]
assign in_boot = word_addr >= BOOT_WORD_BASE;
assign in_table = ~in_boot & (word_addr >= BOOT_WORD_BASE - BOOT_WORDS); // [RL2]
// Lock pairs: [1:0] application, [3:2] table, [5:4] boot; bit0 write, bit1 read
assign sec_lock = in_boot ? lock_bits[5:4] :
                  in_table ? lock_bits[3:2] : lock_bits[1:0]; // [RL2]
assign pc_in_boot = cpu_pc >= BOOT_WORD_BASE;
assign main_rd_ok = sec_lock[1]; // [RL23]
assign main_wr_ok = sec_lock[0] & (flash_from_prog | pc_in_boot); // [RL1] [RL23]

always @* begin
  rd_ok = 1'b1;
  wr_ok = 1'b0;
  case (flash_region)
    REG_MAIN: begin
      rd_ok = main_rd_ok;
      wr_ok = main_wr_ok;
    end
    REG_PSIG: begin
      rd_ok = 1'b1; // [RL3]
      wr_ok = 1'b0; // [RL3]
    end
    REG_USIG: begin
      rd_ok = 1'b1; // [RL5]
      wr_ok = flash_from_prog | pc_in_boot; // [RL5]
    end
    default: rd_ok = 1'b0;
  endcase
end

assign flash_rd_grant = flash_req & ~flash_we & rd_ok;
assign flash_wr_grant = flash_req & flash_we & wr_ok;

always @(posedge mclk or negedge rstn) begin
  if (!rstn)
    flash_refused <= 1'b0;
  else if (flash_req & ((flash_we & ~wr_ok) | (~flash_we & ~rd_ok)))
    flash_refused <= 1'b1; // [RL23]
  else if (dp_rd & (dp_addr == `NMP_STAT_OFS))
    flash_refused <= 1'b0;
end

////////////////////////////////////////////////////////////////////////
// Calibration load after reset
always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    sig_raddr <= 4'h0;
    cal_data <= {8*CAL_WORDS{1'b0}};
    cal_valid <= 1'b0;
  end else if (~cal_valid) begin
    if (sig_raddr != CAL_WORDS[3:0])
      cal_data <= {sig_rdata, cal_data[8*CAL_WORDS-1:8]}; // [RL4]
    if (sig_raddr == CAL_WORDS[3:0])
      cal_valid <= 1'b1; // [RL4]
    else
      sig_raddr <= sig_raddr + 4'h1;
  end
end

////////////////////////////////////////////////////////////////////////
// Data space masters
wire [1:0] space [0:1];
wire ee_mapped;

assign ee_mapped = ctrl[`NMP_CTRL_EEMAP];
assign eeprom_byte_index = ee_addr[4:0]; // [RL22]
assign eeprom_page_index = ee_addr[11:5]; // [RL22]
assign io_short_ok = m_addr[15:0] <= `NMP_SHORT_END; // [RL13]
assign io_bitop_ok = m_addr[15:0] <= `NMP_BITOP_END; // [RL13]
assign io_gpr_sel = m_addr[15:0] <= `NMP_GPR_END; // [RL14]
assign scan_port_en = ~ctrl[`NMP_CTRL_SCANOFF] & ~fuse[`NMP_FUSE_SCANEN]; // [RL19]
assign scan_pins_gpio = ~scan_port_en; // [RL19]

genvar gi;
generate
  for (gi = 0; gi < 2; gi = gi + 1) begin : g_m
    wire [15:0] a;
    wire clash;
    wire start;
    reg [1:0] cnt;
    reg busy;
    reg prev_rd;
    reg [1:0] prev_sp;
    reg [1:0] lat;
    assign a = m_addr[16*gi+15:16*gi];
    assign space[gi] = space_of(a, ee_mapped);
    // CPU wins a clash on the same memory set; DMA waits
    if (gi == 0) begin : g_c
      assign clash = 1'b0;
    end else begin : g_d
      assign clash = m_req[0] & (space[0] == space[1]); // [RL15]
    end
    assign start = m_req[gi] & ~busy & ~clash;
    always @* begin
      lat = `NMP_LAT_IO; // [RL16]
      case (space[gi])
        SEL_SRAM: begin
          if (m_we[gi])
            lat = `NMP_LAT_SRAM_WR; // [RL16]
          else if (m_burst[gi] & prev_rd & (prev_sp == SEL_SRAM))
            lat = `NMP_LAT_SRAM_BURST; // [RL16]
          else
            lat = `NMP_LAT_SRAM_RD; // [RL16]
        end
        SEL_EE: begin
          if (m_we[gi])
            lat = `NMP_LAT_EE_WR; // [RL17]
          else if (m_burst[gi] & prev_rd & (prev_sp == SEL_EE))
            lat = `NMP_LAT_EE_BURST; // [RL17]
          else
            lat = `NMP_LAT_EE_RD; // [RL17]
        end
        default: lat = `NMP_LAT_IO;
      endcase
    end
    always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        cnt <= 2'd0;
        busy <= 1'b0;
        prev_rd <= 1'b0;
        prev_sp <= SEL_NONE;
      end else if (start && lat != 2'd1) begin
        busy <= 1'b1;
        cnt <= lat - 2'd2;
      end else if (busy) begin
        if (cnt == 2'd0) begin
          busy <= 1'b0;
          prev_rd <= ~m_we[gi];
          prev_sp <= space[gi];
        end else begin
          cnt <= cnt - 2'd1;
        end
      end else if (start) begin
        prev_rd <= ~m_we[gi];
        prev_sp <= space[gi];
      end else begin
        prev_rd <= 1'b0;
      end
    end
    assign m_ready[gi] = (start & (lat == 2'd1)) | (busy & (cnt == 2'd0));
    assign m_sel[3*gi] = m_req[gi] & ~clash & (space[gi] == SEL_IO);
    assign m_sel[3*gi+1] = m_req[gi] & ~clash & (space[gi] == SEL_EE);
    assign m_sel[3*gi+2] = m_req[gi] & ~clash & (space[gi] == SEL_SRAM);
    assign m_io_we_ok[gi] = m_we[gi] & (space[gi] == SEL_IO) &
                            ~(ctrl[`NMP_CTRL_SLOCK] & guarded(a)); // [RL20]
  end
endgenerate
endmodule // nmp_top
`default_nettype wire

// >>> test/nmp_far_model.sv
// Far-side model: factory signature row and flash array eraser.
// Assumes the block's calibration fetch and chip-erase handshake on mclk.
`timescale 1ns/100ps
`default_nettype none
module nmp_far_model #(
  parameter logic [7:0] ERASE_CYCLES = 8'h0c
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [3:0] sig_raddr,
  output logic [7:0] sig_rdata,
  input wire logic flash_chip_erase,
  output logic flash_erase_done
);
  logic [7:0] cnt;
  // Fixed factory bytes, no write path
  assign sig_rdata = 8'ha0 + {4'h0, sig_raddr};
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 8'h00;
      flash_erase_done <= 1'b0;
    end else begin
      flash_erase_done <= flash_chip_erase && (cnt == ERASE_CYCLES - 8'h01);
      cnt <= (flash_chip_erase && !flash_erase_done) ? cnt + 8'h01 : 8'h00;
    end
  end
endmodule // nmp_far_model
`default_nettype wire

// >>> test/nmp_check_asserts.sv
// Checker of decode, grant and access timing at the block's ports.
// Assumes one clock domain; bound into every nmp_top instance.
`timescale 1ns/100ps
`default_nettype none
module nmp_check #(
  parameter BOOT_WORD_BASE = 18'h20000
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic flash_req,
  input wire logic flash_we,
  input wire logic [1:0] flash_region,
  input wire logic [18:0] flash_z,
  input wire logic [17:0] cpu_pc,
  input wire logic flash_from_prog,
  input wire logic flash_wr_grant,
  input wire logic [9:0] flash_page_index,
  input wire logic [7:0] flash_word_index,
  input wire logic flash_chip_erase,
  input wire logic flash_erase_done,
  input wire logic [1:0] m_req,
  input wire logic [1:0] m_we,
  input wire logic [1:0] m_burst,
  input wire logic [31:0] m_addr,
  input wire logic [1:0] m_ready,
  input wire logic [5:0] m_sel,
  input wire logic io_short_ok,
  input wire logic io_bitop_ok,
  input wire logic io_gpr_sel
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  page_word_split_a: assert property (flash_page_index == flash_z[18:9]
    && flash_word_index == flash_z[8:1]) else $error("flash index split wrong");
  sig_row_locked_a: assert property (flash_req && flash_we && flash_region == 2'd1
    |-> !flash_wr_grant) else $error("factory row write granted");
  boot_only_write_a: assert property (flash_req && flash_we && flash_region == 2'd0
    && !flash_from_prog && cpu_pc < BOOT_WORD_BASE |-> !flash_wr_grant)
    else $error("flash write granted outside boot");
  erase_hold_a: assert property (flash_chip_erase && !flash_erase_done
    |=> flash_chip_erase) else $error("chip erase ended early");
  short_io_a: assert property (io_short_ok == (m_addr[15:0] <= 16'h003f)
    && io_bitop_ok == (m_addr[15:0] <= 16'h001f)) else $error("short io decode wrong");
  gpr_range_a: assert property (io_gpr_sel == (m_addr[15:0] <= 16'h000f))
    else $error("general register decode wrong");
  sram_decode_a: assert property (m_req[0] && m_addr[15:0] >= 16'h2000
    && m_addr[15:0] <= 16'h5fff |-> m_sel[2:0] == 3'b100) else $error("sram decode wrong");
  io_one_cycle_a: assert property (m_req[0] && m_sel[0] && !$past(m_req[0])
    |-> m_ready[0]) else $error("io access not one cycle");
  sram_read_two_a: assert property (m_req[0] && !m_we[0] && !m_burst[0] && m_sel[2]
    && !$past(m_req[0]) |-> !m_ready[0] ##1 m_ready[0]) else $error("sram read not two");
  ee_read_three_a: assert property (m_req[0] && !m_we[0] && !m_burst[0] && m_sel[1]
    && !$past(m_req[0]) |-> !m_ready[0] [*2] ##1 m_ready[0]) else $error("ee read not three");
  cover property (m_req[0] && m_sel[1] && !m_we[0]);
  cover property (flash_chip_erase ##1 !flash_chip_erase);
  cover property (m_req == 2'b11);
endmodule // nmp_check
bind nmp_top nmp_check #(.BOOT_WORD_BASE(BOOT_WORD_BASE)) chk_u (.mclk(mclk), .rstn(rstn),
  .flash_req(flash_req), .flash_we(flash_we), .flash_region(flash_region),
  .flash_z(flash_z), .cpu_pc(cpu_pc), .flash_from_prog(flash_from_prog),
  .flash_wr_grant(flash_wr_grant), .flash_page_index(flash_page_index),
  .flash_word_index(flash_word_index), .flash_chip_erase(flash_chip_erase),
  .flash_erase_done(flash_erase_done), .m_req(m_req), .m_we(m_we), .m_burst(m_burst),
  .m_addr(m_addr), .m_ready(m_ready), .m_sel(m_sel), .io_short_ok(io_short_ok),
  .io_bitop_ok(io_bitop_ok), .io_gpr_sel(io_gpr_sel));
`default_nettype wire

// >>> test/memory_map_nvm_protection_bench.sv
// Self-checking bench: register bus, flash grants, data map timing, erase.
// Assumes nmp_top, nmp_far_model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module memory_map_nvm_protection_bench;
  typedef struct packed {
    logic [15:0] addr;
    logic we;
    logic [2:0] sel;
    logic [1:0] lat;
  } nmp_row_t;
  localparam logic [23:0] ID_VAL = 24'h3c69d2; // Arbitrary value
  localparam logic [7:0] REV_VAL = 8'h07; // Arbitrary value
  logic mclk, rstn, hsel, hwrite, ccp_open, flash_req, flash_we, flash_from_prog;
  logic prog_fuse_we, prog_lock_we, prog_chip_erase, ok;
  logic [7:0] haddr, prog_fuse_data, prog_lock_data;
  logic [1:0] htrans, flash_region, m_req, m_we, m_burst;
  logic [2:0] hsize, sel;
  logic [31:0] hwdata, m_addr, q;
  logic [18:0] flash_z;
  logic [17:0] cpu_pc;
  wire hreadyout, hresp, flash_rd_grant, flash_wr_grant, flash_chip_erase, flash_erase_done;
  wire cal_valid, io_bitop_ok, io_short_ok, io_gpr_sel, scan_port_en, scan_pins_gpio;
  wire [31:0] hrdata;
  wire [9:0] flash_page_index;
  wire [7:0] flash_word_index, sig_rdata;
  wire [3:0] sig_raddr;
  wire [15:0] cal_data;
  wire [1:0] m_ready, m_io_we_ok;
  wire [5:0] m_sel;
  wire [6:0] eeprom_page_index;
  wire [4:0] eeprom_byte_index;
  int mismatches, comparisons, cycles, lat;
  nmp_row_t rows [0:6] = '{
    '{16'h0000, 1'b0, 3'b001, 2'd1}, '{16'h0fff, 1'b1, 3'b001, 2'd1},
    '{16'h1000, 1'b0, 3'b010, 2'd3}, '{16'h1fff, 1'b1, 3'b010, 2'd1},
    '{16'h2000, 1'b0, 3'b100, 2'd2}, '{16'h5fff, 1'b1, 3'b100, 2'd1},
    '{16'h6000, 1'b0, 3'b000, 2'd1}};

  nmp_top #(.DEVICE_ID(ID_VAL), .REVISION(REV_VAL)) dut_u (.mclk(mclk), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ccp_open(ccp_open), .flash_req(flash_req), .flash_we(flash_we),
    .flash_region(flash_region), .flash_z(flash_z), .cpu_pc(cpu_pc),
    .flash_from_prog(flash_from_prog), .flash_rd_grant(flash_rd_grant),
    .flash_wr_grant(flash_wr_grant), .flash_page_index(flash_page_index),
    .flash_word_index(flash_word_index), .prog_fuse_we(prog_fuse_we),
    .prog_fuse_data(prog_fuse_data), .prog_lock_we(prog_lock_we),
    .prog_lock_data(prog_lock_data), .prog_chip_erase(prog_chip_erase),
    .flash_erase_done(flash_erase_done), .flash_chip_erase(flash_chip_erase),
    .sig_raddr(sig_raddr), .sig_rdata(sig_rdata), .cal_data(cal_data),
    .cal_valid(cal_valid), .m_req(m_req), .m_we(m_we), .m_burst(m_burst), .m_addr(m_addr),
    .m_ready(m_ready), .m_sel(m_sel), .m_io_we_ok(m_io_we_ok), .io_bitop_ok(io_bitop_ok),
    .io_short_ok(io_short_ok), .io_gpr_sel(io_gpr_sel),
    .eeprom_page_index(eeprom_page_index), .eeprom_byte_index(eeprom_byte_index),
    .scan_port_en(scan_port_en), .scan_pins_gpio(scan_pins_gpio));
  nmp_far_model far_u (.mclk(mclk), .rstn(rstn), .sig_raddr(sig_raddr),
    .sig_rdata(sig_rdata), .flash_chip_erase(flash_chip_erase),
    .flash_erase_done(flash_erase_done));

  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'b010;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ahb(a, 1'b0, 32'h0);
    chk(q, e);
  endtask
  task automatic fchk(input logic [1:0] rg, input logic we, input logic pr,
      input logic [17:0] pc, input logic [17:0] wd, input logic exp);
    @(posedge mclk);
    flash_req <= 1'b1;
    flash_region <= rg;
    flash_we <= we;
    flash_from_prog <= pr;
    cpu_pc <= pc;
    flash_z <= {wd, 1'b0};
    #1;
    chk(we ? flash_wr_grant : flash_rd_grant, exp);
    @(posedge mclk);
    flash_req <= 1'b0;
  endtask
  // CPU access held until ready, then one idle cycle
  task automatic acc(input logic [15:0] a, input logic w);
    @(posedge mclk);
    m_req[0] <= 1'b1;
    m_we[0] <= w;
    m_addr[15:0] <= a;
    #1;
    sel = m_sel[2:0];
    ok = m_io_we_ok[0];
    lat = 1;
    while (m_ready[0] !== 1'b1 && lat < 8) begin
      @(posedge mclk);
      #1;
      lat++;
    end
    @(posedge mclk);
    m_req[0] <= 1'b0;
  endtask

  ////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    {hsel, hwrite, ccp_open, flash_req, flash_we, flash_from_prog} = '0;
    {prog_fuse_we, prog_lock_we, prog_chip_erase, haddr, htrans, hsize, hwdata} = '0;
    {prog_fuse_data, prog_lock_data, flash_region, flash_z, cpu_pc} = '0;
    {m_req, m_we, m_burst, m_addr} = '0;
    rstn = 1'b0;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk(cal_valid, 32'h1);
    chk(cal_data, 32'ha1a0);
    rd(8'h04, 32'hff);
    rd(8'h08, 32'hff);
    rd(8'h10, {8'h00, ID_VAL});
    rd(8'h14, {24'h0, REV_VAL});
    rd(8'h1c, 32'h0);
    chk(hresp, 32'h0);
    wr(8'h08, 32'h0);
    rd(8'h08, 32'hff);
    rd(8'h0c, 32'h0a);
    prog_fuse_data <= 8'hfe;
    prog_fuse_we <= 1'b1;
    @(posedge mclk);
    prog_fuse_we <= 1'b0;
    rd(8'h08, 32'hfe);
    wr(8'h00, 32'h3);
    #1;
    chk({scan_port_en, scan_pins_gpio}, 32'h1);
    wr(8'h00, 32'h1);
    #1;
    chk({scan_port_en, scan_pins_gpio}, 32'h2);
    foreach (rows[i]) begin
      acc(rows[i].addr, rows[i].we);
      chk(sel, rows[i].sel);
      chk(lat, rows[i].lat);
    end
    @(posedge mclk);
    m_addr <= 32'h0010_2000;
    m_req <= 2'b11;
    #1;
    chk(m_ready, 32'h2);
    @(posedge mclk);
    #1;
    chk(m_ready[0], 32'h1);
    @(posedge mclk);
    m_req <= 2'b00;
    @(posedge mclk);
    m_burst <= 2'b01;
    m_req <= 2'b01;
    m_addr <= 32'h0000_2000;
    repeat (3) begin
      @(posedge mclk);
      #1;
      chk(m_ready[0], 32'h1);
    end
    @(posedge mclk);
    m_addr <= 32'h0000_1000;
    repeat (2) @(posedge mclk);
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk);
      #1;
      chk(m_ready[0], k % 2);
    end
    @(posedge mclk);
    m_req <= 2'b00;
    m_burst <= 2'b00;
    acc(16'h0040, 1'b1);
    chk(ok, 32'h1);
    wr(8'h00, 32'h5);
    acc(16'h0040, 1'b1);
    chk(ok, 32'h1);
    ccp_open <= 1'b1;
    wr(8'h00, 32'h5);
    ccp_open <= 1'b0;
    acc(16'h0040, 1'b1);
    chk(ok, 32'h0);
    acc(16'h0010, 1'b1);
    chk(ok, 32'h1);
    wr(8'h18, 32'h5a3);
    #1;
    chk({eeprom_page_index, eeprom_byte_index}, 32'h5a3);
    fchk(2'd0, 1'b0, 1'b0, 18'h0, 18'h00100, 1'b1);
    fchk(2'd0, 1'b1, 1'b0, 18'h0, 18'h00100, 1'b0);
    fchk(2'd0, 1'b1, 1'b0, 18'h20000, 18'h00100, 1'b1);
    fchk(2'd0, 1'b1, 1'b0, 18'h20000, 18'h20010, 1'b1);
    fchk(2'd1, 1'b1, 1'b1, 18'h0, 18'h0, 1'b0);
    fchk(2'd1, 1'b0, 1'b0, 18'h0, 18'h0, 1'b1);
    fchk(2'd2, 1'b1, 1'b1, 18'h0, 18'h0, 1'b1);
    wr(8'h04, 32'hfb);
    fchk(2'd0, 1'b1, 1'b1, 18'h0, 18'h1ffff, 1'b0);
    fchk(2'd0, 1'b1, 1'b1, 18'h0, 18'h1efff, 1'b1);
    wr(8'h04, 32'hf8);
    fchk(2'd0, 1'b0, 1'b1, 18'h0, 18'h00100, 1'b0);
    wr(8'h04, 32'hff);
    rd(8'h04, 32'hf8);
    rd(8'h0c, 32'h0d);
    prog_lock_data <= 8'hf0;
    prog_lock_we <= 1'b1;
    @(posedge mclk);
    prog_lock_we <= 1'b0;
    rd(8'h04, 32'hf0);
    prog_chip_erase <= 1'b1;
    @(posedge mclk);
    prog_chip_erase <= 1'b0;
    rd(8'h04, 32'hf0);
    rd(8'h0c, 32'h18);
    while (flash_chip_erase === 1'b1) @(posedge mclk);
    rd(8'h04, 32'hff);
    wr(8'h00, 32'h0);
    acc(16'h1000, 1'b0);
    chk(sel, 32'h0);
    chk(lat, 32'h1);
    end_sim();
  end
endmodule // memory_map_nvm_protection_bench
`default_nettype wire
